// *** design/psave_pkg.sv ***
// Shared constants and types for the power-save clock manager
package psave_pkg;

  localparam int          NUM_MODULES     = 8;
  localparam int          RATIO_W         = 3;
  localparam int          DOZE_CNT_W      = 7;
  localparam logic [2:0]  RATIO_RESET     = 3'h0;
  localparam logic        DOZE_EN_RESET   = 1'h0;
  localparam logic        ROI_RESET       = 1'h0;
  // Clock divider register field positions
  localparam int          ROI_BIT         = 15;
  localparam int          RATIO_MSB       = 14;
  localparam int          RATIO_LSB       = 12;
  localparam int          DOZE_EN_BIT     = 11;
  localparam logic        OPERAND_SLEEP   = 1'h1;
  localparam logic        OPERAND_IDLE    = 1'h0;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTER,
    ST_SLEEP,
    ST_IDLE
  } power_state_t;

endpackage

// *** design/doze_divider.sv ***
// CPU clock enable divider for doze operation
`timescale 1ns/10ps
`default_nettype none
module doze_divider
  import psave_pkg::*;
#(
  parameter int CNT_W = DOZE_CNT_W
)
(
  input  wire logic             i_mclk,
  input  wire logic             i_resetn,
  input  wire logic             i_active,
  input  wire logic [2:0]       i_ratio,
  output logic                  o_tick
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] limit;

  // Longest ratio needs the counter to reach 127
  if (CNT_W < DOZE_CNT_W)
  begin
    $error("doze_divider: counter too narrow for 1:128");
  end

  // Ratio 2**code: tick when counter reaches 2**code - 1
  always_comb
  begin
    limit      = CNT_W'((1 << i_ratio) - 1);
    next_count = '0;
    o_tick     = 1'b1;
    if (i_active)
    begin
      o_tick = (count == limit);
      if (count < limit)
        next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      count <= '0;
    else
      count <= next_count;
  end

endmodule
`default_nettype wire

// *** design/power_save_clock_manager.sv ***
// Sleep, idle, doze and per-module clock gating control
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Sleep operand stops system clock and code; idle halts the CPU and stop-in-idle modules.
// - Sleep shuts the system clock source and its on-chip oscillator.
// - Fail-safe clock monitor is held inactive throughout sleep.
// - Low-power RC clock runs in sleep when watchdog is enabled.
// - Watchdog count cleared before sleep entry completes.
// - System-clocked peripherals off in sleep; change detect may run.
// - Sleep exits on enabled interrupt, any reset, or watchdog time-out.
// - After sleep, the same clock source selection is restored.
// - Idle stops CPU, clears watchdog, keeps system clock running.
// - Low-power RC clock stays on in idle if watchdog or monitor on.
// - Idle exits on enabled interrupt, any reset, or watchdog time-out.
// - Leaving idle re-applies CPU clock at once.
// - Interrupt during power-save instruction deferred until entry, then wakes.
// - Doze divides only CPU clock; peripherals stay full, synchronous.
// - Doze active only while cpu_slowdown_enable bit 11 is set.
// - Ratio field bits 14..12 selects eight ratios, default 1:1.
// - Recover-on-interrupt set returns CPU to full speed on interrupt.
// - Module clock disable gates all clocks; register access blocked.
// - Module enable clear stops function; registers stay accessible.
// - Stop-in-idle bit set halts module during idle; clear keeps running.
// - Ratio code 000 is 1:1, doubling per code to 111 as 1:128.
// - Recover-on-interrupt with interrupt clears slowdown enable bit.
module power_save_clock_manager
  import psave_pkg::*;
#(
  parameter int NMOD = NUM_MODULES
)
(
  input  wire logic             i_mclk,
  input  wire logic             i_resetn,
  // Core request and wake sources
  input  wire logic             i_power_save_instruction,
  input  wire logic             i_power_save_operand,
  input  wire logic             i_irq_pending,
  input  wire logic             i_watchdog_timeout,
  input  wire logic             i_watchdog_enable,
  input  wire logic             i_fail_safe_enable,
  input  wire logic [2:0]       i_clock_source,
  // Clock divider register write port
  input  wire logic             i_clock_divider_reg_write,
  input  wire logic [15:0]      i_clock_divider_reg_wdata,
  output logic [15:0]           o_clock_divider_reg,
  // Per-module controls
  input  wire logic [NMOD-1:0]  i_module_enable,
  input  wire logic [NMOD-1:0]  i_module_clock_disable,
  input  wire logic [NMOD-1:0]  i_module_stop_in_idle,
  input  wire logic [NMOD-1:0]  i_module_ext_clock,
  // Clock enables and status
  output logic                  o_cpu_clock_en,
  output logic                  o_sys_clock_en,
  output logic                  o_osc_enable,
  output logic                  o_low_power_rc_clock_en,
  output logic                  o_fail_safe_active,
  output logic                  o_watchdog_clear,
  output logic [2:0]            o_wake_clock_source,
  output logic [NMOD-1:0]       o_module_clock_en,
  output logic [NMOD-1:0]       o_module_reg_access,
  output logic [NMOD-1:0]       o_module_function_en,
  output logic                  o_in_sleep,
  output logic                  o_in_idle,
  output logic                  o_wake_event
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  // Gating vectors wider than one word are not served
  if (NMOD < 1 || NMOD > 32)
  begin
    $error("power_save_clock_manager: NMOD out of range");
  end
  // The ratio field must match the width that the divider decodes
  if (RATIO_MSB - RATIO_LSB + 1 != RATIO_W)
  begin
    $error("power_save_clock_manager: ratio field width mismatch");
  end
  // Recover and enable bits must sit outside the ratio field
  if (ROI_BIT <= RATIO_MSB || DOZE_EN_BIT >= RATIO_LSB)
  begin
    $error("power_save_clock_manager: divider fields overlap");
  end
  // The divider counter must reach the longest ratio
  if (DOZE_CNT_W < (1 << RATIO_W) - 1)
  begin
    $error("power_save_clock_manager: doze counter too narrow");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-save sequencer state
  power_state_t state;
  power_state_t next_state;
  logic         operand;
  logic         next_operand;
  logic         held_irq;
  logic         next_held_irq;
  logic [2:0]   saved_source;
  logic [2:0]   next_saved_source;
  logic         wdt_clear;
  logic         next_wdt_clear;
  logic         wake;
  logic         next_wake;

  // Wake condition shared by sleep and idle
  function automatic logic wake_cause(input logic irq, input logic wdt);
    return irq | wdt;
  endfunction

  always_comb
  begin
    next_state        = state;
    next_operand      = operand;
    next_held_irq     = 1'b0;
    next_saved_source = saved_source;
    next_wdt_clear    = 1'b0;
    next_wake         = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (i_power_save_instruction)
        begin
          next_state        = ST_ENTER;
          next_operand      = i_power_save_operand;
          next_saved_source = i_clock_source;
          next_wdt_clear    = i_watchdog_enable;
          // interrupt at the strobe edge is kept
          next_held_irq     = wake_cause(i_irq_pending, i_watchdog_timeout);
        end
      end
      ST_ENTER:
      begin
        // One-cycle entry lets the watchdog clear land before sleep
        // interrupt held off
        next_held_irq = held_irq
                        || wake_cause(i_irq_pending, i_watchdog_timeout);
        if (operand == OPERAND_SLEEP)
          next_state = ST_SLEEP;
        else
          next_state = ST_IDLE;
      end
      ST_SLEEP, ST_IDLE:
      begin
        if (held_irq || wake_cause(i_irq_pending, i_watchdog_timeout))
        begin
          next_state = ST_RUN;
          next_wake  = 1'b1;
        end
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  // Any device reset arrives through i_resetn and ends sleep or idle
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state        <= ST_RUN;
      operand      <= OPERAND_IDLE;
      held_irq     <= 1'b0;
      saved_source <= 3'h0;
      wdt_clear    <= 1'b0;
      wake         <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      operand      <= next_operand;
      held_irq     <= next_held_irq;
      saved_source <= next_saved_source;
      wdt_clear    <= next_wdt_clear;
      wake         <= next_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock divider register: recover, ratio and slowdown enable
  logic       recover_on_interrupt;
  logic       next_roi;
  logic [2:0] ratio;
  logic [2:0] next_ratio;
  logic       doze_en;
  logic       next_doze_en;

  // Readback packing; unused bits of the register read zero
  function automatic logic [15:0] pack_divider(
    input logic       recover,
    input logic [2:0] code,
    input logic       enable
  );
    logic [15:0] word;
    word                      = 16'h0000;
    word[ROI_BIT]             = recover;
    word[RATIO_MSB:RATIO_LSB] = code;
    word[DOZE_EN_BIT]         = enable;
    return word;
  endfunction

  always_comb
  begin
    next_roi     = recover_on_interrupt;
    next_ratio   = ratio;
    next_doze_en = doze_en;
    if (i_clock_divider_reg_write)
    begin
      next_roi     = i_clock_divider_reg_wdata[ROI_BIT];
      next_ratio   = i_clock_divider_reg_wdata[RATIO_MSB:RATIO_LSB];
      next_doze_en = i_clock_divider_reg_wdata[DOZE_EN_BIT];
    end
    // A same-cycle write cannot re-arm slowdown while recovering
    // hardware clear wins
    if (recover_on_interrupt && i_irq_pending)
      next_doze_en = 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      recover_on_interrupt     <= ROI_RESET;
      ratio   <= RATIO_RESET;
      doze_en <= DOZE_EN_RESET;
    end
    else
    begin
      recover_on_interrupt     <= next_roi;
      ratio   <= next_ratio;
      doze_en <= next_doze_en;
    end
  end

  always_comb
  begin
    o_clock_divider_reg = pack_divider(recover_on_interrupt, ratio, doze_en);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Doze divider: system clock untouched, CPU gets every 2**ratio-th edge
  logic doze_tick;

  doze_divider #(
    .CNT_W    (DOZE_CNT_W)
  ) u_doze (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_active (doze_en),
    .i_ratio  (ratio),
    .o_tick   (doze_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock enables and module gating
  logic sleeping;
  logic idling;

  assign sleeping = (state == ST_SLEEP);
  assign idling   = (state == ST_IDLE);

  // CPU runs only in RUN, and then only on doze ticks
  function automatic logic cpu_clock_on(
    input power_state_t st,
    input logic         tick
  );
    logic halted;
    halted = (st == ST_ENTER) || (st == ST_SLEEP) || (st == ST_IDLE);
    return !halted && tick;
  endfunction

  // Sleep keeps the RC clock only for the watchdog; monitor is off then
  function automatic logic rc_clock_needed(
    input logic in_sleep,
    input logic wdt_on,
    input logic monitor_on
  );
    if (in_sleep)
      return wdt_on;
    return wdt_on || monitor_on;
  endfunction

  // Per-module clock: gated first, then trimmed by sleep and idle
  function automatic logic module_clock_on(
    input logic clock_disable,
    input logic ext_clock,
    input logic stop_in_idle,
    input logic in_sleep,
    input logic in_idle
  );
    logic clk_on;
    clk_on = !clock_disable;
    if (in_sleep && !ext_clock)
      clk_on = 1'b0;
    if (in_idle && stop_in_idle)
      clk_on = 1'b0;
    return clk_on;
  endfunction

  always_comb
  begin
    o_cpu_clock_en = cpu_clock_on(state, doze_tick);
    o_sys_clock_en = !sleeping;
    o_osc_enable   = !sleeping;
    o_fail_safe_active = i_fail_safe_enable && !sleeping;
    o_low_power_rc_clock_en = rc_clock_needed(sleeping, i_watchdog_enable,
                                              i_fail_safe_enable);
    o_watchdog_clear = wdt_clear;
    o_wake_clock_source = saved_source;
    o_in_sleep   = sleeping;
    o_in_idle    = idling;
    o_wake_event = wake;
    for (int m = 0; m < NMOD; m++)
    begin
      o_module_clock_en[m] = module_clock_on(i_module_clock_disable[m],
                                             i_module_ext_clock[m],
                                             i_module_stop_in_idle[m],
                                             sleeping, idling);
      o_module_reg_access[m] = !i_module_clock_disable[m];
      o_module_function_en[m] = i_module_enable[m]
                                && o_module_clock_en[m];
    end
  end

endmodule
`default_nettype wire

// *** tb/psave_core_model.sv ***
// Processor-side model that issues power-save instructions
`timescale 1ns/10ps
`default_nettype none
module psave_core_model
(
  input  wire logic i_mclk,
  output var logic  o_power_save_instruction,
  output var logic  o_power_save_operand
);
  initial
  begin
    o_power_save_instruction = 1'h0;
    o_power_save_operand = 1'h0;
  end
  task automatic issue(input logic op);
    @(negedge i_mclk);
    o_power_save_instruction = 1'h1;
    o_power_save_operand = op;
    @(negedge i_mclk);
    o_power_save_instruction = 1'h0;
    // Operand means nothing without the strobe, so do not leave it valid
    o_power_save_operand = ~op;
  endtask
endmodule
`default_nettype wire

// *** tb/psave_assertions.sv ***
// Port checker for the power-save clock manager
`timescale 1ns/10ps
`default_nettype none
module psave_checker
  import psave_pkg::*;
#(
  parameter int NMOD = NUM_MODULES
)
(
  input wire logic            i_mclk,
  input wire logic            i_resetn,
  input wire logic            i_power_save_instruction,
  input wire logic            i_power_save_operand,
  input wire logic            i_irq_pending,
  input wire logic            i_watchdog_enable,
  input wire logic [NMOD-1:0] i_module_clock_disable,
  input wire logic [15:0]     o_clock_divider_reg,
  input wire logic            o_cpu_clock_en,
  input wire logic            o_sys_clock_en,
  input wire logic            o_osc_enable,
  input wire logic            o_low_power_rc_clock_en,
  input wire logic            o_fail_safe_active,
  input wire logic            o_watchdog_clear,
  input wire logic [NMOD-1:0] o_module_clock_en,
  input wire logic            o_in_sleep,
  input wire logic            o_in_idle,
  input wire logic            o_wake_event
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_take;
    i_power_save_instruction && !o_in_sleep && !o_in_idle;
  endsequence
  sequence s_wake;
    (o_in_sleep || o_in_idle) && i_irq_pending;
  endsequence
  sequence s_woken;
    !o_in_sleep && !o_in_idle && o_wake_event;
  endsequence
  a_sleep_entry: assert property (
    s_take ##0 i_power_save_operand |=> !o_cpu_clock_en ##1 o_in_sleep)
    else $error("sleep entry out of step");
  a_idle_entry: assert property (
    s_take ##0 !i_power_save_operand |=> !o_cpu_clock_en
    ##1 (o_in_idle && o_sys_clock_en)) else $error("idle entry wrong");
  a_watchdog_clear: assert property (
    s_take |=> (o_watchdog_clear == $past(i_watchdog_enable))
    ##1 !o_watchdog_clear) else $error("watchdog clear wrong");
  a_sleep_clocks_off: assert property (o_in_sleep |->
    !o_sys_clock_en && !o_osc_enable && !o_fail_safe_active)
    else $error("clock alive in sleep");
  a_rc_in_sleep: assert property (
    o_in_sleep |-> o_low_power_rc_clock_en == i_watchdog_enable)
    else $error("rc clock wrong in sleep");
  a_wake_exit: assert property (
    s_wake |=> !o_in_sleep && !o_in_idle && o_wake_event)
    else $error("no wake on interrupt");
  a_full_speed: assert property (
    !o_clock_divider_reg[DOZE_EN_BIT] && !o_in_sleep && !o_in_idle
    && !$past(i_power_save_instruction) |-> o_cpu_clock_en)
    else $error("cpu clock slowed without doze");
  a_recover_clear: assert property (
    o_clock_divider_reg[ROI_BIT] && o_clock_divider_reg[DOZE_EN_BIT]
    && i_irq_pending |=> !o_clock_divider_reg[DOZE_EN_BIT])
    else $error("slowdown not cleared");
  a_gate_off: assert property (
    (o_module_clock_en & i_module_clock_disable) == '0)
    else $error("gated module still clocked");
  a_held_wake: assert property (
    s_take ##0 i_irq_pending |-> ##2 (o_in_sleep || o_in_idle) ##1 s_woken)
    else $error("held interrupt did not wake");
endmodule
bind power_save_clock_manager psave_checker #(.NMOD(NMOD)) i_chk (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the power-save clock manager
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import psave_pkg::*;
  logic        i_mclk, i_resetn, i_power_save_instruction;
  logic        i_power_save_operand, i_irq_pending, i_watchdog_timeout;
  logic        i_watchdog_enable, i_fail_safe_enable, i_clock_divider_reg_write;
  logic [2:0]  i_clock_source, o_wake_clock_source;
  logic [15:0] i_clock_divider_reg_wdata, o_clock_divider_reg;
  logic [7:0]  i_module_enable, i_module_clock_disable, i_module_stop_in_idle;
  logic [7:0]  i_module_ext_clock, o_module_clock_en, o_module_reg_access;
  logic [7:0]  o_module_function_en;
  logic        o_cpu_clock_en, o_sys_clock_en, o_osc_enable, o_watchdog_clear;
  logic        o_low_power_rc_clock_en, o_fail_safe_active, o_in_sleep;
  logic        o_in_idle, o_wake_event;
  int          fail_count, n_compared, c;

  power_save_clock_manager i_power_save_clock_manager (.*);
  psave_core_model i_psave_core_model (.i_mclk(i_mclk),
    .o_power_save_instruction(i_power_save_instruction),
    .o_power_save_operand(i_power_save_operand));

  task automatic step(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic wr(input logic [15:0] d);
    @(negedge i_mclk);
    i_clock_divider_reg_write = 1'h1;
    i_clock_divider_reg_wdata = d;
    @(negedge i_mclk);
    i_clock_divider_reg_write = 1'h0;
  endtask
  task automatic irq_pulse;
    i_irq_pending = 1'h1;
    step(1);
    i_irq_pending = 1'h0;
  endtask
  task automatic count_cpu(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge i_mclk);
      if (o_cpu_clock_en === 1'h1) k++;
    end
  endtask
  task automatic print_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'h0;
    forever #25 i_mclk = ~i_mclk;
  end
  // Whole run needs about 3140 cycles; allow over six times that
  initial
  begin
    #1_000_000;
    fail_count++;
    print_verdict;
  end

  initial
  begin
    {i_resetn, i_irq_pending, i_watchdog_timeout, i_clock_divider_reg_write} = '0;
    i_watchdog_enable = 1'h1;
    i_fail_safe_enable = 1'h1;
    i_clock_source = 3'h5;
    i_clock_divider_reg_wdata = 16'h0000;
    i_module_enable = 8'hff;
    i_module_clock_disable = 8'h00;
    i_module_stop_in_idle = 8'hf0;
    i_module_ext_clock = 8'h0f;
    step(8);
    i_resetn = 1'h1;
    `CHK(o_clock_divider_reg, 16'h0000)
    i_psave_core_model.issue(OPERAND_SLEEP);
    `CHK({o_watchdog_clear, o_cpu_clock_en}, 2'h2)
    step(1);
    `CHK({o_in_sleep, o_sys_clock_en, o_fail_safe_active}, 3'h4)
    `CHK(o_osc_enable, 1'h0)
    `CHK(o_module_clock_en, 8'h0f)
    i_clock_source = 3'h2;
    step(3);
    `CHK(o_in_sleep, 1'h1)
    irq_pulse();
    `CHK({o_in_sleep, o_wake_event}, 2'h1)
    `CHK(o_wake_clock_source, 3'h5)
    i_psave_core_model.issue(OPERAND_IDLE);
    step(1);
    `CHK({o_in_idle, o_sys_clock_en, o_cpu_clock_en}, 3'h6)
    `CHK(o_module_function_en, 8'h0f)
    `CHK(o_low_power_rc_clock_en, 1'h1)
    i_watchdog_timeout = 1'h1;
    step(1);
    i_watchdog_timeout = 1'h0;
    `CHK({o_in_idle, o_cpu_clock_en}, 2'h1)
    // Interrupt already pending when the instruction issues
    i_irq_pending = 1'h1;
    i_psave_core_model.issue(OPERAND_IDLE);
    // Interrupt gone before entry ends: only the held copy can wake
    i_irq_pending = 1'h0;
    step(1);
    `CHK(o_in_idle, 1'h1)
    step(1);
    `CHK({o_in_idle, o_wake_event}, 2'h1)
    i_module_clock_disable = 8'h81;
    i_module_enable = 8'h3d;
    step(1);
    `CHK(o_module_clock_en, 8'h7e)
    `CHK(o_module_reg_access, 8'h7e)
    `CHK(o_module_function_en, 8'h3c)
    for (int r = 0; r < 8; r++)
    begin
      wr({1'h0, r[2:0], 1'h1, 11'h7ff});
      `CHK(o_clock_divider_reg, {1'h0, r[2:0], 12'h800})
      step(128);
      count_cpu(256, c);
      `CHK(c, 256 >> r)
      `CHK(o_sys_clock_en, 1'h1)
    end
    wr(16'hb800);
    irq_pulse();
    `CHK(o_clock_divider_reg, 16'hb000)
    count_cpu(16, c);
    `CHK(c, 16)
    wr(16'h3800);
    irq_pulse();
    `CHK(o_clock_divider_reg, 16'h3800)
    wr(16'h0000);
    i_watchdog_enable = 1'h0;
    i_psave_core_model.issue(OPERAND_SLEEP);
    step(1);
    `CHK({o_in_sleep, o_low_power_rc_clock_en}, 2'h2)
    i_resetn = 1'h0;
    step(1);
    i_resetn = 1'h1;
    `CHK({o_in_sleep, o_cpu_clock_en}, 2'h1)
    print_verdict;
  end
endmodule
`default_nettype wire
